/* File: rtl/umd_regs.vh */
// constants of the multidrop serial port: mode codes, oversampling and timing counts
// assumes inclusion by every design file of the block; holds definitions only
// What this block does
// - Data-available status is 1 while a received byte waits, 0 when empty.
// - With flow hold on, sample clear-to-send one clock before each start bit.
// - A character already shifting out is always finished despite clear-to-send.
// - Multidrop flag bit is sent after the eight data bits, before the stops.
// - In multidrop mode the ninth bit is the flag; parity is not used.
// - Address schemes act only with multidrop enabled; two-bit field picks the scheme.
// - Mode 01: interrupt on each address byte; data bytes interrupt only on errors.
// - Mode 00 with multidrop: interrupt on every received byte.
// - Received multidrop bit status shows the flag of the current byte.
// - Mode 10: compare addresses, drop mismatching address and its data bytes.
// - Hardware match: matching address and following data bytes interrupt.
// - First-byte flag is 1 on first data byte of accepted frame, else 0.
// - Every new address is compared again; a match restarts the frame.
// - Mode 11: like mode 10 but address bytes are not stored and raise no interrupt.
// - Receive interrupt fires on data plus errors, or on errors only.
// - Driver enable asserts when a byte is written for transmission.
// - With flow hold off, driver enable leads the start bit by one to two bit periods.
// - Driver enable covers the frame and drops one clock after the last stop.
// - Driver enable stays on across back-to-back characters.
// - A polarity input selects active-high or active-low driver enable.
// - Character: low start, eight bits LSB first, optional ninth, one or two stops.
// - With flow hold on, transmission starts only while clear-to-send is low.
`ifndef UMD_REGS_VH
`define UMD_REGS_VH
`define UMD_CLK_PERIOD_NS 8
`define UMD_OVERSAMPLE 16
`define UMD_TICK_LAST 4'hF
`define UMD_TICK_MID 4'h7
`define UMD_DE_LEAD_TICKS 5'h11
`define UMD_CTS_SAMPLE_LEAD_CYCLES 1
`define UMD_DE_TAIL_CYCLES 1
`define UMD_MPMD_ALL 2'h0
`define UMD_MPMD_ADDR 2'h1
`define UMD_MPMD_HW 2'h2
`define UMD_MPMD_HW_NOADDR 2'h3
`endif

/* File: rtl/umd_baud.v */
// 16x oversampling tick generator for the multidrop serial port
// assumes a divisor held stable while the port is active; zero acts as one
`timescale 1ns/100ps
`include "umd_regs.vh"
module umd_baud #(
   parameter DIV_W = 16
) (
   input wire clk_in,
   input wire rst_n_in,
   input wire ce_in,
   input wire [DIV_W-1:0] div_in,
   output reg tick_out
);
   reg [DIV_W-1:0] cnt;

   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt <= {DIV_W{1'b0}};
         tick_out <= 1'b0;
      end else if (ce_in) begin
         if (cnt + {{(DIV_W-1){1'b0}}, 1'b1} >= div_in) begin
            cnt <= {DIV_W{1'b0}};
            tick_out <= 1'b1;
         end else begin
            cnt <= cnt + {{(DIV_W-1){1'b0}}, 1'b1};
            tick_out <= 1'b0;
         end
      end
   end
endmodule // umd_baud

/* File: rtl/umd_rx_shift.v */
// receive shifter: start check at mid bit, eight data bits LSB first, optional ninth, stop
// assumes rxd already synchronous to the clock and a 16x tick from the baud generator
`timescale 1ns/100ps
`include "umd_regs.vh"
module umd_rx_shift (
   input wire clk_in,
   input wire rst_n_in,
   input wire ce_in,
   input wire tick_in,
   input wire enable_in,
   input wire rxd_in,
   input wire nine_bits_in,
   output reg done_out,
   output reg [7:0] data_out,
   output reg ninth_out,
   output reg frame_err_out
);
   localparam ST_IDLE = 2'h0;
   localparam ST_START = 2'h1;
   localparam ST_SHIFT = 2'h2;
   localparam ST_STOP = 2'h3;

   reg [1:0] state;
   reg [3:0] cnt;
   reg [3:0] nbit;
   reg [8:0] shreg;
   wire [3:0] last_bit;

   assign last_bit = nine_bits_in ? 4'h8 : 4'h7;

   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state <= ST_IDLE;
         cnt <= 4'h0;
         nbit <= 4'h0;
         shreg <= 9'h000;
         done_out <= 1'b0;
         data_out <= 8'h00;
         ninth_out <= 1'b0;
         frame_err_out <= 1'b0;
      end else if (ce_in) begin
         done_out <= 1'b0;
         if (!enable_in) begin
            state <= ST_IDLE;
         end else if (tick_in) begin
            case (state)
               ST_IDLE: begin
                  cnt <= 4'h0;
                  if (!rxd_in) begin
                     state <= ST_START;
                  end
               end
               ST_START: begin
                  if (cnt == `UMD_TICK_MID) begin
                     cnt <= 4'h0;
                     nbit <= 4'h0;
                     state <= rxd_in ? ST_IDLE : ST_SHIFT;
                  end else begin
                     cnt <= cnt + 4'h1;
                  end
               end
               ST_SHIFT: begin
                  if (cnt == `UMD_TICK_LAST) begin
                     cnt <= 4'h0;
                     shreg <= {rxd_in, shreg[8:1]};
                     nbit <= nbit + 4'h1;
                     if (nbit == last_bit) begin
                        state <= ST_STOP;
                     end
                  end else begin
                     cnt <= cnt + 4'h1;
                  end
               end
               ST_STOP: begin
                  if (cnt == `UMD_TICK_LAST) begin
                     cnt <= 4'h0;
                     done_out <= 1'b1;
                     frame_err_out <= !rxd_in;
                     data_out <= nine_bits_in ? shreg[7:0] : shreg[8:1];
                     ninth_out <= nine_bits_in & shreg[8];
                     state <= ST_IDLE;
                  end else begin
                     cnt <= cnt + 4'h1;
                  end
               end
               default: state <= ST_IDLE;
            endcase
         end
      end
   end
endmodule // umd_rx_shift

/* File: rtl/umd_uart.v */
// multidrop serial port top: transmitter with flow hold and driver enable,
// receive status, multidrop address filtering and receive interrupt
// assumes all inputs synchronous to REF_CLK_IN; configuration stable while enabled
`timescale 1ns/100ps
`include "umd_regs.vh"
module umd_uart #(
   parameter DIV_W = 16
) (
   input wire REF_CLK_IN,
   input wire RST_N_IN,
   input wire CLK_EN_IN,
   input wire [DIV_W-1:0] BAUD_DIV_IN,
   input wire TRANSMITTER_ENABLE_IN,
   input wire RECEIVE_ENABLE_IN,
   input wire FLOW_HOLD_ENABLE_IN,
   input wire PARITY_ENABLE_IN,
   input wire PARITY_ODD_IN,
   input wire TWO_STOP_IN,
   input wire MULTIDROP_ENABLE_IN,
   input wire [1:0] MULTIDROP_MODE_SEL_IN,
   input wire MULTIDROP_FLAG_BIT_IN,
   input wire [7:0] ADDR_COMPARE_IN,
   input wire RX_IRQ_ERRORS_ONLY_IN,
   input wire DRIVE_EN_POLARITY_IN,
   input wire [7:0] TX_DATA_IN,
   input wire TX_WRITE_IN,
   input wire RX_READ_IN,
   input wire RXD_IN,
   input wire CTS_N_IN,
   output reg TXD_OUT,
   output reg TRANSCEIVER_DRIVE_EN_OUT,
   output reg TX_EMPTY_OUT,
   output reg [7:0] RX_DATA_OUT,
   output reg RX_DATA_AVAILABLE_OUT,
   output reg RX_MULTIDROP_BIT_OUT,
   output reg FIRST_BYTE_OF_FRAME_OUT,
   output reg RX_FRAMING_ERR_OUT,
   output reg RX_PARITY_ERR_OUT,
   output reg RX_OVERRUN_OUT,
   output reg RX_IRQ_OUT
);
   localparam TX_IDLE = 3'h0;
   localparam TX_LEAD = 3'h1;
   localparam TX_START = 3'h2;
   localparam TX_DATA = 3'h3;
   localparam TX_NINTH = 3'h4;
   localparam TX_STOP = 3'h5;

   wire tick;
   wire rx_done;
   wire [7:0] rx_byte;
   wire rx_ninth;
   wire rx_ferr;
   wire nine_bits;
   wire tx_bit_end;
   wire flow_held;
   wire tx_go;

   reg [2:0] tx_state;
   reg [3:0] tx_tick;
   reg [4:0] lead_cnt;
   reg [2:0] tx_nbit;
   reg tx_second_stop;
   reg [7:0] tx_hold;
   reg tx_hold_flag;
   reg tx_full;
   reg [7:0] tx_shift;
   reg tx_ninth;

   reg frame_accept;
   reg first_pending;
   reg rx_is_addr;
   reg rx_store;
   reg rx_irq_ok;
   reg rx_first;
   reg rx_perr;

   // ninth bit carries the flag in multidrop mode, parity otherwise
   assign nine_bits = MULTIDROP_ENABLE_IN | PARITY_ENABLE_IN;
   assign tx_bit_end = tick & (tx_tick == `UMD_TICK_LAST);
   // clear-to-send is looked at on the tick cycle, one clock before the start bit drives
   assign flow_held = FLOW_HOLD_ENABLE_IN & CTS_N_IN;
   assign tx_go = tx_full & TRANSMITTER_ENABLE_IN & !flow_held;

   umd_baud #(
      .DIV_W(DIV_W)
   ) u_baud (
      .clk_in(REF_CLK_IN),
      .rst_n_in(RST_N_IN),
      .ce_in(CLK_EN_IN),
      .div_in(BAUD_DIV_IN),
      .tick_out(tick)
   );

   umd_rx_shift u_rx (
      .clk_in(REF_CLK_IN),
      .rst_n_in(RST_N_IN),
      .ce_in(CLK_EN_IN),
      .tick_in(tick),
      .enable_in(RECEIVE_ENABLE_IN),
      .rxd_in(RXD_IN),
      .nine_bits_in(nine_bits),
      .done_out(rx_done),
      .data_out(rx_byte),
      .ninth_out(rx_ninth),
      .frame_err_out(rx_ferr)
   );

   // transmitter
   always @(posedge REF_CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         tx_state <= TX_IDLE;
         tx_tick <= 4'h0;
         lead_cnt <= 5'h00;
         tx_nbit <= 3'h0;
         tx_second_stop <= 1'b0;
         tx_hold <= 8'h00;
         tx_hold_flag <= 1'b0;
         tx_full <= 1'b0;
         tx_shift <= 8'h00;
         tx_ninth <= 1'b0;
         TXD_OUT <= 1'b1;
         TX_EMPTY_OUT <= 1'b1;
         TRANSCEIVER_DRIVE_EN_OUT <= 1'b0;
      end else if (CLK_EN_IN) begin
         if (TX_WRITE_IN) begin
            tx_hold <= TX_DATA_IN;
            tx_hold_flag <= MULTIDROP_FLAG_BIT_IN;
            tx_full <= 1'b1;
         end
         if (tick && tx_state != TX_IDLE && tx_state != TX_LEAD) begin
            tx_tick <= tx_tick + 4'h1;
         end
         case (tx_state)
            TX_IDLE: begin
               lead_cnt <= 5'h00;
               if (tx_full) begin
                  tx_state <= TX_LEAD;
               end
            end
            TX_LEAD: begin
               // a bit period and two ticks of setup (18 ticks), counted in ticks from entry to TX_LEAD
               if (tick) begin
                  if (lead_cnt < `UMD_DE_LEAD_TICKS) begin
                     lead_cnt <= lead_cnt + 5'h01;
                  end else if (tx_go) begin
                     tx_state <= TX_START;
                     tx_tick <= 4'h0;
                     tx_shift <= tx_hold;
                     tx_ninth <= MULTIDROP_ENABLE_IN ? tx_hold_flag :
                        (^tx_hold) ^ PARITY_ODD_IN;
                     tx_full <= TX_WRITE_IN;
                     TXD_OUT <= 1'b0;
                  end
               end
            end
            TX_START: begin
               if (tx_bit_end) begin
                  tx_state <= TX_DATA;
                  tx_nbit <= 3'h0;
                  TXD_OUT <= tx_shift[0];
                  tx_shift <= {1'b0, tx_shift[7:1]};
               end
            end
            TX_DATA: begin
               // clear-to-send is not looked at here, so the character always completes
               if (tx_bit_end) begin
                  tx_nbit <= tx_nbit + 3'h1;
                  if (tx_nbit != 3'h7) begin
                     TXD_OUT <= tx_shift[0];
                     tx_shift <= {1'b0, tx_shift[7:1]};
                  end else if (nine_bits) begin
                     tx_state <= TX_NINTH;
                     TXD_OUT <= tx_ninth;
                  end else begin
                     tx_state <= TX_STOP;
                     tx_second_stop <= 1'b0;
                     TXD_OUT <= 1'b1;
                  end
               end
            end
            TX_NINTH: begin
               if (tx_bit_end) begin
                  tx_state <= TX_STOP;
                  tx_second_stop <= 1'b0;
                  TXD_OUT <= 1'b1;
               end
            end
            TX_STOP: begin
               if (tx_bit_end) begin
                  if (TWO_STOP_IN && !tx_second_stop) begin
                     tx_second_stop <= 1'b1;
                  end else if (tx_go) begin
                     // next character follows at once, driver enable stays on
                     tx_state <= TX_START;
                     tx_shift <= tx_hold;
                     tx_ninth <= MULTIDROP_ENABLE_IN ? tx_hold_flag :
                        (^tx_hold) ^ PARITY_ODD_IN;
                     tx_full <= TX_WRITE_IN;
                     TXD_OUT <= 1'b0;
                  end else if (tx_full) begin
                     tx_state <= TX_LEAD;
                     lead_cnt <= `UMD_DE_LEAD_TICKS;
                  end else begin
                     tx_state <= TX_IDLE;
                  end
               end
            end
            default: tx_state <= TX_IDLE;
         endcase
         TX_EMPTY_OUT <= !(tx_full | TX_WRITE_IN);
         // registered from the state, so it falls one clock after the last stop ends
         TRANSCEIVER_DRIVE_EN_OUT <= (tx_state != TX_IDLE || tx_full || TX_WRITE_IN) ~^
            DRIVE_EN_POLARITY_IN;
      end
   end

   // multidrop acceptance of a completed character
   always @* begin
      rx_is_addr = MULTIDROP_ENABLE_IN & rx_ninth;
      rx_store = 1'b1;
      rx_irq_ok = 1'b1;
      rx_first = 1'b0;
      rx_perr = PARITY_ENABLE_IN & !MULTIDROP_ENABLE_IN &
         (rx_ninth != ((^rx_byte) ^ PARITY_ODD_IN));
      if (MULTIDROP_ENABLE_IN) begin
         case (MULTIDROP_MODE_SEL_IN)
            `UMD_MPMD_ALL: begin
               rx_irq_ok = 1'b1;
            end
            `UMD_MPMD_ADDR: begin
               rx_irq_ok = rx_is_addr;
            end
            `UMD_MPMD_HW: begin
               if (rx_is_addr) begin
                  rx_store = (rx_byte == ADDR_COMPARE_IN);
                  rx_irq_ok = rx_store;
               end else begin
                  rx_store = frame_accept;
                  rx_first = first_pending;
               end
            end
            `UMD_MPMD_HW_NOADDR: begin
               if (rx_is_addr) begin
                  rx_store = 1'b0;
               end else begin
                  rx_store = frame_accept;
                  rx_first = first_pending;
               end
            end
            default: rx_store = 1'b1;
         endcase
      end
   end

   // receive status, data and interrupt
   always @(posedge REF_CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         frame_accept <= 1'b0;
         first_pending <= 1'b0;
         RX_DATA_OUT <= 8'h00;
         RX_DATA_AVAILABLE_OUT <= 1'b0;
         RX_MULTIDROP_BIT_OUT <= 1'b0;
         FIRST_BYTE_OF_FRAME_OUT <= 1'b0;
         RX_FRAMING_ERR_OUT <= 1'b0;
         RX_PARITY_ERR_OUT <= 1'b0;
         RX_OVERRUN_OUT <= 1'b0;
         RX_IRQ_OUT <= 1'b0;
      end else if (CLK_EN_IN) begin
         RX_IRQ_OUT <= 1'b0;
         if (RX_READ_IN) begin
            RX_DATA_AVAILABLE_OUT <= 1'b0;
            RX_FRAMING_ERR_OUT <= 1'b0;
            RX_PARITY_ERR_OUT <= 1'b0;
            RX_OVERRUN_OUT <= 1'b0;
         end
         if (rx_done) begin
            if (rx_is_addr && MULTIDROP_MODE_SEL_IN[1]) begin
               // every address is compared again and restarts or ends the frame
               frame_accept <= (rx_byte == ADDR_COMPARE_IN);
               first_pending <= (rx_byte == ADDR_COMPARE_IN);
            end else if (rx_store && frame_accept) begin
               first_pending <= 1'b0;
            end
            if (rx_store) begin
               if (RX_DATA_AVAILABLE_OUT && !RX_READ_IN) begin
                  // unread byte is kept; the new one is lost
                  RX_OVERRUN_OUT <= 1'b1;
                  RX_IRQ_OUT <= 1'b1;
               end else begin
                  RX_DATA_OUT <= rx_byte;
                  RX_DATA_AVAILABLE_OUT <= 1'b1;
                  RX_MULTIDROP_BIT_OUT <= rx_is_addr;
                  FIRST_BYTE_OF_FRAME_OUT <= rx_first;
                  RX_FRAMING_ERR_OUT <= rx_ferr;
                  RX_PARITY_ERR_OUT <= rx_perr;
                  RX_IRQ_OUT <= rx_ferr | rx_perr |
                     (rx_irq_ok & !RX_IRQ_ERRORS_ONLY_IN);
               end
            end
         end
      end
   end
endmodule // umd_uart

/* File: testbench/umd_uart_sva.sv */
// checker on the ports of the multidrop serial port top
// assumes transmit enable held high and a fixed baud divisor
`timescale 1ns/100ps
module umd_uart_sva #(
   parameter DIV_W = 16
) (
   input wire REF_CLK_IN,
   input wire RST_N_IN,
   input wire CLK_EN_IN,
   input wire [DIV_W-1:0] BAUD_DIV_IN,
   input wire FLOW_HOLD_ENABLE_IN,
   input wire MULTIDROP_ENABLE_IN,
   input wire [1:0] MULTIDROP_MODE_SEL_IN,
   input wire RX_IRQ_ERRORS_ONLY_IN,
   input wire DRIVE_EN_POLARITY_IN,
   input wire TX_WRITE_IN,
   input wire CTS_N_IN,
   input wire TXD_OUT,
   input wire TRANSCEIVER_DRIVE_EN_OUT,
   input wire TX_EMPTY_OUT,
   input wire RX_DATA_AVAILABLE_OUT,
   input wire RX_MULTIDROP_BIT_OUT,
   input wire FIRST_BYTE_OF_FRAME_OUT,
   input wire RX_FRAMING_ERR_OUT,
   input wire RX_PARITY_ERR_OUT,
   input wire RX_OVERRUN_OUT,
   input wire RX_IRQ_OUT
);
   wire de_act = TRANSCEIVER_DRIVE_EN_OUT == DRIVE_EN_POLARITY_IN;
   wire errs = RX_FRAMING_ERR_OUT | RX_PARITY_ERR_OUT | RX_OVERRUN_OUT;
   reg [15:0] lead;
   reg sent;
   // cycles of driver enable ahead of the first start bit of an episode
   always @(posedge REF_CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         lead <= 16'h0000;
         sent <= 1'b0;
      end else if (!de_act) begin
         lead <= 16'h0000;
         sent <= 1'b0;
      end else begin
         if (lead != 16'hFFFF) lead <= lead + 16'h0001;
         if (!TXD_OUT) sent <= 1'b1;
      end
   end
   default clocking cb @(posedge REF_CLK_IN); endclocking
   default disable iff (!RST_N_IN);
   property p_de_write;
      TX_WRITE_IN && CLK_EN_IN |=> de_act && !TX_EMPTY_OUT;
   endproperty
   a_de_write: assert property (p_de_write) else $error("no drive after write");
   property p_de_frame;
      !de_act |-> TXD_OUT;
   endproperty
   a_de_frame: assert property (p_de_frame) else $error("line active without drive");
   property p_de_lead;
      $fell(TXD_OUT) && !sent && !FLOW_HOLD_ENABLE_IN |->
         lead >= 16 * BAUD_DIV_IN && lead <= 32 * BAUD_DIV_IN;
   endproperty
   a_de_lead: assert property (p_de_lead) else $error("drive lead out of range");
   property p_cts_hold;
      !sent && FLOW_HOLD_ENABLE_IN && $past(CTS_N_IN) && $past(CTS_N_IN, 2) |-> !$fell(TXD_OUT);
   endproperty
   a_cts_hold: assert property (p_cts_hold) else $error("start while held");
   property p_err_only;
      RX_IRQ_OUT && RX_IRQ_ERRORS_ONLY_IN |-> errs;
   endproperty
   a_err_only: assert property (p_err_only) else $error("data irq in errors-only");
   property p_irq_avail;
      RX_IRQ_OUT && !errs |-> RX_DATA_AVAILABLE_OUT;
   endproperty
   a_irq_avail: assert property (p_irq_avail) else $error("irq without data");
   property p_addr_irq;
      RX_IRQ_OUT && MULTIDROP_ENABLE_IN && MULTIDROP_MODE_SEL_IN == 2'h1 && !errs
         |-> RX_MULTIDROP_BIT_OUT;
   endproperty
   a_addr_irq: assert property (p_addr_irq) else $error("data irq in address mode");
   property p_noaddr_irq;
      RX_IRQ_OUT && MULTIDROP_ENABLE_IN && MULTIDROP_MODE_SEL_IN == 2'h3 && !errs
         |-> !RX_MULTIDROP_BIT_OUT;
   endproperty
   a_noaddr_irq: assert property (p_noaddr_irq) else $error("address irq in mode 3");
   property p_first;
      $rose(FIRST_BYTE_OF_FRAME_OUT) |->
         MULTIDROP_ENABLE_IN && MULTIDROP_MODE_SEL_IN[1] && !RX_MULTIDROP_BIT_OUT;
   endproperty
   a_first: assert property (p_first) else $error("first flag out of place");
   c_irq: cover property (RX_IRQ_OUT);
   c_de_drop: cover property ($fell(de_act));
   c_first: cover property ($rose(FIRST_BYTE_OF_FRAME_OUT));
endmodule // umd_uart_sva
bind umd_uart umd_uart_sva #(.DIV_W(DIV_W)) u_umd_uart_sva (.*);

/* File: testbench/umd_node.sv */
// remote node on the shared line: sends frames, captures frames, drives clear-to-send
// assumes 16 clocks per bit and an idle-high line
`timescale 1ns/100ps
module umd_node (
   input wire clk_in,
   input wire txd_in,
   input wire nine_in,
   output reg rxd_out,
   output reg cts_n_out
);
   reg [9:0] last;
   reg [9:0] f;
   integer nframes;
   integer i;
   initial begin
      rxd_out = 1'b1;
      cts_n_out = 1'b0;
      nframes = 0;
   end
   // start low, data lsb first, optional ninth, stop at given level
   task send(input [7:0] d, input b9, input use9, input stp);
      integer k;
      integer n;
      reg [9:0] v;
      begin
         v = use9 ? {stp, b9, d} : {1'b0, stp, d};
         n = use9 ? 10 : 9;
         @(posedge clk_in) rxd_out <= 1'b0;
         for (k = 0; k < n; k = k + 1) begin
            repeat (16) @(posedge clk_in);
            rxd_out <= v[k];
         end
         repeat (16) @(posedge clk_in);
         rxd_out <= 1'b1;
         repeat (16) @(posedge clk_in);
      end
   endtask
   // changed on an edge well ahead of the next start
   task hold(input h);
      @(posedge clk_in) cts_n_out <= h;
   endtask
   always begin
      @(negedge txd_in);
      f = 10'h3FF;
      repeat (8) @(posedge clk_in);
      for (i = 0; i < 10; i = i + 1) begin
         if (i < 9 || nine_in) begin
            repeat (16) @(posedge clk_in);
            f[i] = txd_in;
         end
      end
      last = f;
      nframes = nframes + 1;
   end
endmodule // umd_node

/* File: testbench/testbench.sv */
// self-checking bench for the multidrop serial port
// assumes divisor one, so a bit lasts 16 clocks
`timescale 1ns/100ps
module testbench;
   reg clk = 1'b0;
   reg rst_n = 1'b0;
   reg flow = 1'b0;
   reg parity_enable = 1'b0;
   reg odd = 1'b0;
   reg two = 1'b0;
   reg multidrop_enable = 1'b0;
   reg [1:0] mode = 2'h0;
   reg flag = 1'b0;
   reg eonly = 1'b0;
   reg pol = 1'b1;
   reg [7:0] tdata = 8'h00;
   reg wr = 1'b0;
   reg rd = 1'b0;
   reg nine = 1'b0;
   reg ce = 1'b1;
   reg transmitter_enable = 1'b1;
   reg ren = 1'b1;
   reg [7:0] addr = 8'h12;
   wire rxd, cts_n, txd, de, empty, avail, mpb, first, ferr, perr, ovr, irq;
   wire [7:0] rdata;
   integer n_fail = 0;
   integer n_compared = 0;
   integer irq_cnt = 0;
   integer de_off = 0;
   integer k;
   integer n0;
   integer c0;
   umd_uart u_umd_uart (.REF_CLK_IN(clk), .RST_N_IN(rst_n), .CLK_EN_IN(ce),
      .BAUD_DIV_IN(16'h0001), .TRANSMITTER_ENABLE_IN(transmitter_enable), .RECEIVE_ENABLE_IN(ren),
      .FLOW_HOLD_ENABLE_IN(flow), .PARITY_ENABLE_IN(parity_enable), .PARITY_ODD_IN(odd),
      .TWO_STOP_IN(two), .MULTIDROP_ENABLE_IN(multidrop_enable), .MULTIDROP_MODE_SEL_IN(mode),
      .MULTIDROP_FLAG_BIT_IN(flag), .ADDR_COMPARE_IN(addr), .RX_IRQ_ERRORS_ONLY_IN(eonly),
      .DRIVE_EN_POLARITY_IN(pol), .TX_DATA_IN(tdata), .TX_WRITE_IN(wr), .RX_READ_IN(rd),
      .RXD_IN(rxd), .CTS_N_IN(cts_n), .TXD_OUT(txd), .TRANSCEIVER_DRIVE_EN_OUT(de),
      .TX_EMPTY_OUT(empty), .RX_DATA_OUT(rdata), .RX_DATA_AVAILABLE_OUT(avail),
      .RX_MULTIDROP_BIT_OUT(mpb), .FIRST_BYTE_OF_FRAME_OUT(first),
      .RX_FRAMING_ERR_OUT(ferr), .RX_PARITY_ERR_OUT(perr), .RX_OVERRUN_OUT(ovr),
      .RX_IRQ_OUT(irq));
   umd_node u_umd_node (.clk_in(clk), .txd_in(txd), .nine_in(nine), .rxd_out(rxd),
      .cts_n_out(cts_n));
   initial begin
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
      if (de !== pol) de_off <= de_off + 1;
   end
   task final_report;
      begin
         $display("compared %0d, failed %0d", n_compared, n_fail);
         if (n_fail == 0 && n_compared > 0) $display("TEST PASSED");
         else $display("TEST FAILED");
         $finish;
      end
   endtask
   task chk(input [15:0] got, input [15:0] exp);
      begin
         n_compared = n_compared + 1;
         if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task bound(input integer n);
      if (n >= 4000) begin
         chk(16'h0000, 16'h0001);
         final_report;
      end
   endtask
   task wait_fr(input integer n);
      begin
         for (k = 0; u_umd_node.nframes < n && k < 4000; k = k + 1) @(posedge clk);
         bound(k);
      end
   endtask
   task tx(input [7:0] d, input b9);
      begin
         @(posedge clk);
         tdata <= d;
         flag <= b9;
         wr <= 1'b1;
         @(posedge clk);
         wr <= 1'b0;
      end
   endtask
   task txf(input [7:0] d, input b9, input [9:0] exp);
      begin
         n0 = u_umd_node.nframes;
         tx(d, b9);
         wait_fr(n0 + 1);
         chk(u_umd_node.last, exp);
      end
   endtask
   task wait_start;
      begin
         for (k = 0; txd !== 1'b0 && k < 4000; k = k + 1) @(posedge clk);
         bound(k);
      end
   endtask
   task cfg(input m, input [1:0] s);
      begin
         @(posedge clk);
         multidrop_enable <= m;
         mode <= s;
         @(posedge clk);
      end
   endtask
   // e = expected irq, available, first-byte, multidrop bit
   task rx(input [7:0] d, input b9, input [3:0] e);
      begin
         c0 = irq_cnt;
         u_umd_node.send(d, b9, multidrop_enable, 1'b1);
         chk(irq_cnt - c0, e[3]);
         chk({avail, first & avail, mpb & avail}, e[2:0]);
         if (e[2]) chk(rdata, d);
         @(posedge clk) rd <= 1'b1;
         @(posedge clk) rd <= 1'b0;
         @(posedge clk) chk(avail, 1'b0);
      end
   endtask
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      txf(8'hA5, 1'b0, 10'h3A5);
      repeat (40) @(posedge clk);
      chk(de, 1'b0);
      cfg(1'b1, 2'h0);
      parity_enable <= 1'b1;
      nine <= 1'b1;
      txf(8'h3D, 1'b0, 10'h23D);
      txf(8'h3D, 1'b1, 10'h33D);
      cfg(1'b0, 2'h0);
      two <= 1'b1;
      txf(8'h3D, 1'b0, 10'h33D);
      odd <= 1'b1;
      txf(8'h3D, 1'b0, 10'h23D);
      parity_enable <= 1'b0;
      nine <= 1'b0;
      two <= 1'b0;
      pol <= 1'b0;
      repeat (40) @(posedge clk);
      chk(de, 1'b1);
      // a write while the clock enable is low must not be taken
      ce <= 1'b0;
      tx(8'h47, 1'b0);
      chk(de, 1'b1);
      chk(empty, 1'b1);
      ce <= 1'b1;
      n0 = u_umd_node.nframes;
      tx(8'h11, 1'b0);
      wait_start;
      c0 = de_off;
      tx(8'h22, 1'b0);
      wait_fr(n0 + 2);
      chk(de_off - c0, 16'h0000);
      chk(u_umd_node.last, 10'h322);
      pol <= 1'b1;
      flow <= 1'b1;
      u_umd_node.hold(1'b1);
      n0 = u_umd_node.nframes;
      tx(8'h44, 1'b0);
      repeat (200) @(posedge clk);
      chk(u_umd_node.nframes - n0, 16'h0000);
      chk(txd, 1'b1);
      u_umd_node.hold(1'b0);
      wait_fr(n0 + 1);
      chk(u_umd_node.last, 10'h344);
      tx(8'h45, 1'b0);
      wait_start;
      tx(8'h46, 1'b0);
      repeat (40) @(posedge clk);
      u_umd_node.hold(1'b1);
      wait_fr(n0 + 2);
      chk(u_umd_node.last, 10'h345);
      repeat (200) @(posedge clk);
      chk(u_umd_node.nframes - n0, 16'h0002);
      u_umd_node.hold(1'b0);
      wait_fr(n0 + 3);
      chk(u_umd_node.last, 10'h346);
      flow <= 1'b0;
      cfg(1'b1, 2'h0);
      rx(8'h12, 1'b1, 4'b1101);
      rx(8'h55, 1'b0, 4'b1100);
      cfg(1'b1, 2'h1);
      rx(8'h12, 1'b1, 4'b1101);
      rx(8'h55, 1'b0, 4'b0100);
      cfg(1'b1, 2'h2);
      rx(8'h34, 1'b1, 4'b0000);
      rx(8'h66, 1'b0, 4'b0000);
      rx(8'h12, 1'b1, 4'b1101);
      rx(8'h77, 1'b0, 4'b1110);
      rx(8'h78, 1'b0, 4'b1100);
      rx(8'h12, 1'b1, 4'b1101);
      rx(8'h79, 1'b0, 4'b1110);
      cfg(1'b1, 2'h3);
      rx(8'h12, 1'b1, 4'b0000);
      rx(8'h9A, 1'b0, 4'b1110);
      rx(8'h9B, 1'b0, 4'b1100);
      rx(8'h34, 1'b1, 4'b0000);
      rx(8'h9C, 1'b0, 4'b0000);
      cfg(1'b0, 2'h1);
      rx(8'h5A, 1'b0, 4'b1100);
      ren <= 1'b0;
      rx(8'h5E, 1'b0, 4'b0000);
      ren <= 1'b1;
      eonly <= 1'b1;
      rx(8'h5B, 1'b0, 4'b0100);
      c0 = irq_cnt;
      u_umd_node.send(8'h5C, 1'b0, 1'b0, 1'b0);
      chk(irq_cnt - c0, 16'h0001);
      chk(ferr, 1'b1);
      // second byte while the first is unread: overrun, first byte kept
      u_umd_node.send(8'h5D, 1'b0, 1'b0, 1'b1);
      chk(ovr, 1'b1);
      chk(rdata, 8'h5C);
      chk(irq_cnt - c0, 16'h0002);
      @(posedge clk) rd <= 1'b1;
      @(posedge clk) rd <= 1'b0;
      parity_enable <= 1'b1;
      // odd parity over 8'h5C wants a one; a zero is sent
      u_umd_node.send(8'h5C, 1'b0, 1'b1, 1'b1);
      chk(perr, 1'b1);
      chk(irq_cnt - c0, 16'h0003);
      final_report;
   end
endmodule // testbench
